// ===== src/pwst_pkg.sv
/*
  Constants and types of the power-up self-test sequencer and its
  four-indicator display. Assumes a 10 MHz board clock.
*/
package pwst_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned SELFTEST_LIMIT_MS = 200;
  localparam int unsigned SELFTEST_LIMIT_CYC =
    SELFTEST_LIMIT_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Routine order and display codes
  localparam logic [3:0] ROUTINE_FIRST = 4'h0;
  localparam logic [3:0] ROUTINE_LAST  = 4'h9;
  localparam logic [3:0] CODE_DONE     = 4'h0;
  localparam logic [3:0] CODE_ABORT    = 4'hF;
  localparam logic [3:0] ROUTINE_CODE [0:15] = '{
    4'hF, 4'hD, 4'h5, 4'h7, 4'h3, 4'h1, 4'h9, 4'hB,
    4'hA, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0
  };

  // ==========================================================
  // Reset values
  localparam logic [3:0] LED_RESET = 4'hF;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_ISSUE = 4'h1,
    ST_WAIT  = 4'h2,
    ST_FAIL  = 4'h4,
    ST_DONE  = 4'h8
  } pwst_state_e;

  typedef struct packed {
    logic       start;
    logic [3:0] routine;
  } pwst_chk_req_s;

  typedef struct packed {
    logic done;
    logic pass;
  } pwst_chk_rsp_s;

  typedef struct packed {
    logic ac_low_n;
    logic dc_low_n;
    logic init_n;
  } pwst_pins_s;

endpackage

// ===== src/pwst_sync.sv
/*
  Two-flop synchroniser for the backplane power-fail and init pins.
  Assumes the pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module pwst_sync (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire pwst_pkg::pwst_pins_s d,
  output pwst_pkg::pwst_pins_s   q
);

  pwst_pkg::pwst_pins_s meta_q;

  // ==========================================================
  // Two stages; pins idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      q      <= '1;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ===== src/pwst_wdog.sv
/*
  Saturating watchdog counter for the whole self-test sequence.
  Assumes clear and run come from logic on the same clock.
*/
`timescale 1ns/1ps
module pwst_wdog #(
  parameter int unsigned LIMIT = pwst_pkg::SELFTEST_LIMIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic run,
  output logic      expired
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_q;

  // ==========================================================
  // Count while running, stop at the limit
  assign expired = (cnt_q == LIM);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (clear) begin
        cnt_q <= '0;
      end else if (run && !expired) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule

// ===== src/pwst_selftest.sv
/*
  Power-up self-test sequencer with four status indicators. Runs the
  fixed series of internal check routines through an internal check
  engine, shows progress, latches a failure code, and gates host
  commands until the board has passed.
  Assumes chk_rsp comes from logic on clk; the backplane pins are
  asynchronous and arrive active low.
*/
`timescale 1ns/1ps
module pwst_selftest #(
  parameter int unsigned SELFTEST_LIMIT_CYC =
    pwst_pkg::SELFTEST_LIMIT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 ac_low_n,
  input  wire logic                 dc_low_n,
  input  wire logic                 init_n,
  output pwst_pkg::pwst_chk_req_s   chk_req,
  input  wire pwst_pkg::pwst_chk_rsp_s chk_rsp,
  input  wire logic                 host_cmd_valid,
  output logic                      host_cmd_ready,
  output logic [3:0]                led_q,
  output logic                      selftest_busy,
  output logic                      selftest_ok,
  output logic                      selftest_abandoned
);

  // ==========================================================
  // Declarations
  pwst_pkg::pwst_pins_s  pins_raw;
  pwst_pkg::pwst_pins_s  pins_s;
  pwst_pkg::pwst_state_e state_q;
  pwst_pkg::pwst_state_e state_d;
  logic [3:0]            rt_q;
  logic [3:0]            rt_d;
  logic [3:0]            led_d;
  logic                  dc_prev_q;
  logic                  restart;
  logic                  lines_ok;
  logic                  pass_eff;
  logic                  is_last;
  logic                  wd_expired;
  logic                  wd_run;
  logic                  in_wait;
  logic                  in_issue;
  logic                  in_fail;
  logic                  in_done;

  // ==========================================================
  // Pin synchronisation
  assign pins_raw.ac_low_n = ac_low_n;
  assign pins_raw.dc_low_n = dc_low_n;
  assign pins_raw.init_n   = init_n;

  pwst_sync u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (pins_raw),
    .q   (pins_s)
  );

  // ==========================================================
  // Power-up event: DC-low released restarts the sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      dc_prev_q <= 1'b1;
    end else if (ce) begin
      dc_prev_q <= pins_s.dc_low_n;
    end
  end

  assign restart = pins_s.dc_low_n & ~dc_prev_q;

  // ==========================================================
  // Watchdog over the whole sequence
  assign wd_run = in_issue | in_wait;

  pwst_wdog #(
    .LIMIT (SELFTEST_LIMIT_CYC)
  ) u_wdog (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .clear   (restart),
    .run     (wd_run),
    .expired (wd_expired)
  );

  // ==========================================================
  // State decode
  assign in_issue = (state_q == pwst_pkg::ST_ISSUE);
  assign in_wait  = (state_q == pwst_pkg::ST_WAIT);
  assign in_fail  = (state_q == pwst_pkg::ST_FAIL);
  assign in_done  = (state_q == pwst_pkg::ST_DONE);

  // ==========================================================
  // Pass decision
  // Both power-fail lines and init must read negated
  assign lines_ok = pins_s.ac_low_n & pins_s.dc_low_n & pins_s.init_n;
  // Only the engine result and backplane lines count, no drive
  assign pass_eff = chk_rsp.pass &
                    ((rt_q != pwst_pkg::ROUTINE_FIRST) | lines_ok);
  assign is_last  = (rt_q == pwst_pkg::ROUTINE_LAST);

  // ==========================================================
  // Check engine request
  assign chk_req.start   = ce & in_issue & ~restart;
  assign chk_req.routine = rt_q;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    rt_d    = rt_q;
    if (restart) begin
      state_d = pwst_pkg::ST_ISSUE;
      rt_d    = pwst_pkg::ROUTINE_FIRST;
    end else begin
      unique case (state_q)
        pwst_pkg::ST_ISSUE: begin
          state_d = pwst_pkg::ST_WAIT;
        end
        pwst_pkg::ST_WAIT: begin
          if (wd_expired) begin
            state_d = pwst_pkg::ST_FAIL;
          end else if (chk_rsp.done) begin
            if (!pass_eff) begin
              state_d = pwst_pkg::ST_FAIL;
            end else if (is_last) begin
              state_d = pwst_pkg::ST_DONE;
            end else begin
              state_d = pwst_pkg::ST_ISSUE;
              rt_d    = rt_q + 4'h1;
            end
          end
        end
        pwst_pkg::ST_FAIL: begin
          state_d = pwst_pkg::ST_FAIL;
        end
        pwst_pkg::ST_DONE: begin
          state_d = pwst_pkg::ST_DONE;
        end
        default: begin
          state_d = pwst_pkg::ST_FAIL;
        end
      endcase
    end
  end

  // ==========================================================
  // Display: code of the running routine, held on failure
  assign led_d = (state_d == pwst_pkg::ST_DONE) ? pwst_pkg::CODE_DONE
               : pwst_pkg::ROUTINE_CODE[rt_d];

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pwst_pkg::ST_ISSUE;
      rt_q    <= pwst_pkg::ROUTINE_FIRST;
      led_q   <= pwst_pkg::LED_RESET;
    end else if (ce) begin
      state_q <= state_d;
      rt_q    <= rt_d;
      led_q   <= led_d;
    end
  end

  // ==========================================================
  // Host command gate and status
  assign selftest_abandoned = in_fail & (led_q == pwst_pkg::CODE_ABORT);
  assign host_cmd_ready     = in_done & ce;
  assign selftest_busy      = in_issue | in_wait;
  assign selftest_ok        = in_done;

  // ==========================================================
  // Assertions
  property p_start_then_wait;
    @(posedge clk) disable iff (rst)
      (in_issue && ce && !restart) |=> in_wait;
  endproperty
  a_start_then_wait: assert property (p_start_then_wait)
    else $error("issue state did not move to wait");

  property p_progress_code;
    @(posedge clk) disable iff (rst)
      (in_issue || in_wait) |-> (led_q == pwst_pkg::ROUTINE_CODE[rt_q]);
  endproperty
  a_progress_code: assert property (p_progress_code)
    else $error("indicators do not show running routine");

  property p_fail_hold;
    @(posedge clk) disable iff (rst)
      (in_fail && !restart) |=> (in_fail && $stable(led_q));
  endproperty
  a_fail_hold: assert property (p_fail_hold)
    else $error("failure code not held");

  property p_done_dark;
    @(posedge clk) disable iff (rst)
      in_done |-> (led_q == pwst_pkg::CODE_DONE);
  endproperty
  a_done_dark: assert property (p_done_dark)
    else $error("indicators lit after completion");

  property p_prio_lines;
    @(posedge clk) disable iff (rst)
      (ce && in_wait && rt_q == pwst_pkg::ROUTINE_FIRST && chk_rsp.done
       && !lines_ok && !restart)
      |=> (in_fail && led_q == pwst_pkg::CODE_ABORT);
  endproperty
  a_prio_lines: assert property (p_prio_lines)
    else $error("priority check passed with lines asserted");

  property p_order;
    @(posedge clk) disable iff (rst)
      (ce && in_wait && chk_rsp.done && pass_eff && !is_last
       && !restart && !wd_expired)
      |=> (rt_q == $past(rt_q) + 4'h1) ##1 in_wait;
  endproperty
  a_order: assert property (p_order)
    else $error("routine order broken");

  property p_last_done;
    @(posedge clk) disable iff (rst)
      (ce && in_wait && is_last && chk_rsp.done && pass_eff
       && !restart && !wd_expired) |=> in_done;
  endproperty
  a_last_done: assert property (p_last_done)
    else $error("last routine pass did not complete");

  property p_abandon_deaf;
    @(posedge clk) disable iff (rst)
      selftest_abandoned |-> !host_cmd_ready;
  endproperty
  a_abandon_deaf: assert property (p_abandon_deaf)
    else $error("host command accepted while abandoned");

  property p_watchdog;
    @(posedge clk) disable iff (rst)
      (ce && in_wait && wd_expired && !restart) |=> in_fail;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog expiry did not stop the sequence");

  property p_restart_first;
    @(posedge clk) disable iff (rst)
      (ce && restart) |=> (in_issue && rt_q == pwst_pkg::ROUTINE_FIRST
                           && led_q == pwst_pkg::CODE_ABORT);
  endproperty
  a_restart_first: assert property (p_restart_first)
    else $error("restart did not begin at first routine");

  property p_cmd_refused;
    @(posedge clk) disable iff (rst)
      (host_cmd_valid && !in_done) |-> !host_cmd_ready;
  endproperty
  a_cmd_refused: assert property (p_cmd_refused)
    else $error("host command taken before completion");

  property p_abandon_stay;
    @(posedge clk) disable iff (rst)
      (selftest_abandoned && !restart) |=> selftest_abandoned;
  endproperty
  a_abandon_stay: assert property (p_abandon_stay)
    else $error("abandoned board left its stopped state");

  property p_fail_quiet;
    @(posedge clk) disable iff (rst)
      in_fail |-> !chk_req.start;
  endproperty
  a_fail_quiet: assert property (p_fail_quiet)
    else $error("routine started after a failure");

  property p_done_hold;
    @(posedge clk) disable iff (rst)
      (in_done && !restart) |=> (in_done && led_q == pwst_pkg::CODE_DONE);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("completion state not held dark");

  property p_start_pulse;
    @(posedge clk) disable iff (rst)
      chk_req.start |=> !chk_req.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("engine start held longer than one cycle");

  property p_wait_engine;
    @(posedge clk) disable iff (rst)
      (ce && in_wait && !chk_rsp.done && !wd_expired && !restart)
      |=> (in_wait && $stable(rt_q));
  endproperty
  a_wait_engine: assert property (p_wait_engine)
    else $error("sequence moved without an engine result");

  property p_routine_range;
    @(posedge clk) disable iff (rst)
      (in_issue || in_wait) |-> (rt_q <= pwst_pkg::ROUTINE_LAST);
  endproperty
  a_routine_range: assert property (p_routine_range)
    else $error("routine index beyond the last routine");

endmodule

// ===== tb/pwst_engine_model.sv
/*
  Behavioural model of the internal check engine behind the sequencer.
  Assumes chk_req comes from the sequencer on the same clock.
*/
`timescale 1ns/1ps
module pwst_engine_model (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire pwst_pkg::pwst_chk_req_s chk_req,
  input  wire logic                    fail_en,
  input  wire logic [3:0]              fail_at,
  input  wire logic [7:0]              delay,
  output pwst_pkg::pwst_chk_rsp_s      chk_rsp
);
  // ==========================================================
  // Engine
  logic [7:0] cnt_q;
  logic       busy_q;
  logic [3:0] rt_q;

  // Checks internal circuits only, no drive input
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q  <= 1'b0;
      cnt_q   <= 8'h00;
      rt_q    <= 4'h0;
      chk_rsp <= '0;
    end else begin
      chk_rsp <= '0;
      if (chk_req.start) begin
        busy_q <= 1'b1;
        cnt_q  <= delay;
        rt_q   <= chk_req.routine;
      end else if (busy_q) begin
        if (cnt_q <= 8'h01) begin
          busy_q       <= 1'b0;
          chk_rsp.done <= 1'b1;
          chk_rsp.pass <= !(fail_en && rt_q == fail_at);
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

// ===== tb/powerup_selftest_led_display_tb_top.sv
/*
  Self-checking bench of the power-up self-test sequencer.
  Assumes the check engine model and a 10 MHz clock.
*/
`timescale 1ns/1ps
module powerup_selftest_led_display_tb_top;
  // ==========================================================
  // Signals
  logic                    clk;
  logic                    rst;
  logic                    ac_low_n;
  logic                    dc_low_n;
  logic                    init_n;
  logic                    host_cmd_valid;
  logic                    fail_en;
  logic [3:0]              fail_at;
  logic [7:0]              delay;
  pwst_pkg::pwst_chk_req_s chk_req;
  pwst_pkg::pwst_chk_rsp_s chk_rsp;
  logic                    host_cmd_ready;
  logic [3:0]              led_q;
  logic                    selftest_busy;
  logic                    selftest_ok;
  logic                    selftest_abandoned;
  int                      mismatches;
  int                      checks_done;
  logic [3:0]              seen[$];
  logic [3:0] exp_code [0:9] = '{4'hF, 4'hD, 4'h5, 4'h7, 4'h3,
                                 4'h1, 4'h9, 4'hB, 4'hA, 4'h2};

  pwst_selftest #(.SELFTEST_LIMIT_CYC(64)) dut_u (
    .clk(clk), .rst(rst), .ce(1'b1), .ac_low_n(ac_low_n),
    .dc_low_n(dc_low_n), .init_n(init_n), .chk_req(chk_req),
    .chk_rsp(chk_rsp), .host_cmd_valid(host_cmd_valid),
    .host_cmd_ready(host_cmd_ready), .led_q(led_q),
    .selftest_busy(selftest_busy), .selftest_ok(selftest_ok),
    .selftest_abandoned(selftest_abandoned));

  pwst_engine_model eng_u (
    .clk(clk), .rst(rst), .chk_req(chk_req), .fail_en(fail_en),
    .fail_at(fail_at), .delay(delay), .chk_rsp(chk_rsp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  task automatic step;
    @(posedge clk);
    #10;
  endtask

  task automatic cmp_code(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_code({3'h0, got}, {3'h0, exp});
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (12) step;
    rst = 1'b0;
  endtask

  // Records the code shown at each routine start until idle
  task automatic collect;
    int i;
    seen.delete();
    for (i = 0; i < 400; i++) begin
      if (chk_req.start === 1'b1) begin
        cmp_code(chk_req.routine, 4'(seen.size()));
        seen.push_back(led_q);
      end
      if (selftest_busy === 1'b0) break;
      step;
    end
    if (i == 400) begin
      mismatches++;
      final_report;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic sc_pass;
    fail_en = 1'b0;
    do_reset;
    collect;
    cmp_code(4'(seen.size()), 4'hA);
    foreach (seen[i]) cmp_code(seen[i], exp_code[i]);
    cmp_code(led_q, 4'h0);
    cmp_flag(selftest_ok, 1'b1);
    cmp_flag(host_cmd_ready, 1'b1);
  endtask

  task automatic sc_fail(input logic [3:0] k);
    fail_en = 1'b1;
    fail_at = k;
    do_reset;
    collect;
    cmp_code(4'(seen.size()), k + 4'h1);
    cmp_code(led_q, exp_code[k]);
    repeat (20) step;
    cmp_code(led_q, exp_code[k]);
    cmp_flag(selftest_busy, 1'b0);
    cmp_flag(host_cmd_ready, 1'b0);
    cmp_flag(selftest_abandoned, k == 4'h0);
    fail_en = 1'b0;
  endtask

  task automatic sc_pin(input logic [2:0] pins);
    {ac_low_n, dc_low_n, init_n} = pins;
    do_reset;
    collect;
    cmp_code(led_q, 4'hF);
    cmp_flag(selftest_abandoned, 1'b1);
    {ac_low_n, dc_low_n, init_n} = 3'h7;
  endtask

  task automatic sc_restart;
    int i;
    sc_pass;
    dc_low_n = 1'b0;
    repeat (5) step;
    dc_low_n = 1'b1;
    for (i = 0; i < 10 && selftest_busy !== 1'b1; i++) step;
    if (i == 10) begin
      mismatches++;
      final_report;
    end
    cmp_flag(selftest_busy, 1'b1);
    cmp_code(led_q, 4'hF);
    collect;
    cmp_code(4'(seen.size()), 4'hA);
    cmp_code(led_q, 4'h0);
  endtask

  task automatic sc_watchdog;
    delay = 8'h10;
    do_reset;
    collect;
    cmp_flag(selftest_ok, 1'b0);
    cmp_code(led_q, exp_code[3]);
    cmp_flag(host_cmd_ready, 1'b0);
    delay = 8'h01;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {ac_low_n, dc_low_n, init_n} = 3'h7;
    host_cmd_valid = 1'b1;
    fail_en = 1'b0;
    fail_at = 4'h0;
    delay = 8'h01;
    mismatches = 0;
    checks_done = 0;
    sc_pass;
    for (int k = 0; k < 10; k++) sc_fail(4'(k));
    sc_pin(3'h3);
    sc_pin(3'h5);
    sc_pin(3'h6);
    sc_restart;
    sc_watchdog;
    final_report;
  end
endmodule
